// ### mcs_pkg.sv
package mcs_pkg;

	// command codes for the registers of this block
	localparam logic [7:0] CMD_READ_STATUS1   = 8'h02;
	localparam logic [7:0] CMD_READ_STATUS2   = 8'h32;
	localparam logic [7:0] CMD_READ_CHAN_CFG  = 8'h33;
	localparam logic [7:0] CMD_WRITE_CHAN_CFG = 8'h34;

	localparam logic [7:0] CHAN_CFG_RESET  = 8'h00;
	localparam logic [7:0] CHAN_CFG_WMASK  = 8'hFE;
	localparam logic [7:0] STATUS_BUSY_VAL = 8'h80;

	// channel disable bit positions
	localparam int DIS_REMOTE1  = 7;
	localparam int DIS_REMOTE2  = 6;
	localparam int DIS_INTERNAL = 5;
	localparam int DIS_INPUT3   = 4;
	localparam int DIS_INPUT2   = 3;
	localparam int DIS_INPUT1   = 2;
	localparam int DIS_SUPPLY   = 1;

	// mask bit positions in configuration byte 1
	localparam int MASK_ALL     = 7;
	localparam int MASK_REMOTE1 = 5;
	localparam int MASK_REMOTE2 = 4;
	localparam int MASK_INPUT3  = 3;

	// temperature channel index: 0 internal, 1 remote1, 2 remote2
	localparam int NUM_TEMP = 3;
	localparam int NUM_VOLT = 4;

	typedef enum {
		MCS_IDLE,
		MCS_SCAN
	} mcs_conv_state_t;

endpackage

// ### mcs_flag_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mcs_flag_if;
	logic [6:0] event_set;
	logic [6:0] clear;
	logic [6:0] flags;
	modport owner (input event_set, input clear, output flags);
	modport user (output event_set, output clear, input flags);
endinterface
`default_nettype wire

// ### mcs_sticky_flags.sv
`timescale 1ns/1ps
`default_nettype none
module mcs_sticky_flags
(
	// clock and reset
	input  wire logic   clk_i,
	input  wire logic   reset_i,
	// flag group
	mcs_flag_if.owner   flag_bus
);
	typedef struct packed {
		logic [6:0] flags;
	} mcs_sticky_state_t;

	mcs_sticky_state_t state;
	mcs_sticky_state_t next_state;

	// set wins over clear
	always_comb
	begin
		next_state.flags = (state.flags & ~flag_bus.clear) | flag_bus.event_set;
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			state <= '0;
		else
			state <= next_state;
	end

	assign flag_bus.flags = state.flags;
endmodule
`default_nettype wire

// ### mcs_config_status.sv
// Behaviour
// - channel config bit 7 skips remote channel 1 in the scan
// - channel config bit 6 stops remote channel 2 measurement
// - channel config bit 5 stops internal temperature measurement
// - bits 4..1 disable input3, input2, input1, supply measurement
// - bit 0 reserved, resets to zero, has no effect
// - status 1 bit 7 reads one while converting
// - status 1 bits 6,5 latch internal high and low alarms
// - status 1 bits 4,3 latch remote1 high and low alarms
// - status 1 bits 1,0 latch remote2 high and low alarms
// - latched temperature alarms clear on reset or status 1 read
// - status 1 bit 2 follows diode 1 open or short
// - status 2 bit 7 follows internal shutdown limit exceed
// - status 2 bits 6,5 follow remote1, remote2 shutdown exceed
// - status 2 bit 4 follows diode 2 open or short
// - status 2 bits 3..0 latch voltage window alarms, clear on read
// - converter runs from reset; status 1 is 80h busy, else 00h
// - config 1 masks gate alarm output; remote masks gate shutdown too
`timescale 1ns/1ps
`default_nettype none
module mcs_config_status
(
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 reset_i,
	// register access from the serial interface
	input  wire logic                 reg_write_i,
	input  wire logic                 reg_read_i,
	input  wire logic [7:0]           reg_cmd_i,
	input  wire logic [7:0]           reg_wdata_i,
	output var  logic [7:0]           reg_rdata_o,
	// configuration byte 1 held elsewhere
	input  wire logic [7:0]           alarm_mask_cfg_i,
	input  wire logic                 standby_i,
	// converter handshake
	input  wire logic                 conv_done_i,
	output var  logic                 conv_busy_o,
	output var  logic [2:0]           conv_channel_o,
	output var  logic [6:0]           meas_enable_o,
	// comparator results, pulses at end of a channel conversion
	input  wire logic [mcs_pkg::NUM_TEMP-1:0] temp_above_alarm_i,
	input  wire logic [mcs_pkg::NUM_TEMP-1:0] temp_below_alarm_i,
	input  wire logic [mcs_pkg::NUM_TEMP-1:0] temp_above_shutdown_i,
	input  wire logic [mcs_pkg::NUM_VOLT-1:0] volt_out_of_window_i,
	input  wire logic                 diode1_fault_i,
	input  wire logic                 diode2_fault_i,
	// device outputs
	output var  logic                 alarm_n_o,
	output var  logic                 thermal_shutdown_output_o
);
	import mcs_pkg::*;

	typedef struct packed {
		mcs_conv_state_t  conv_state;
		logic [2:0]       channel;
		logic [7:0]       chan_cfg;
		logic [NUM_TEMP-1:0] shutdown_flags;
		logic             diode1_fault_flag;
		logic             diode2_fault_flag;
		logic [7:0]       rdata;
		logic             alarm_n;
		logic             shutdown_out;
	} mcs_state_t;

	mcs_state_t state;
	mcs_state_t next_state;

	mcs_flag_if flag_bus ();

	logic [6:0] chan_en;
	logic [6:0] raw_set;
	logic       internal_temp_above_alarm;
	logic       internal_temp_below_alarm;
	logic       remote1_temp_above_alarm;
	logic       remote1_temp_below_alarm;
	logic       remote2_temp_above_alarm;
	logic       remote2_temp_below_alarm;
	logic [3:0] volt_alarms;
	logic [7:0] status1;
	logic [7:0] status2;
	logic       rd_status1;
	logic       rd_status2;

	mcs_sticky_flags u_flags
	(
		.clk_i    (clk_i),
		.reset_i  (reset_i),
		.flag_bus (flag_bus)
	);

	// enable per channel: 0 internal, 1 remote1, 2 remote2, 3 supply, 4 input1, 5 input2, 6 input3
	always_comb
	begin
		chan_en[0] = ~state.chan_cfg[DIS_INTERNAL];
		chan_en[1] = ~state.chan_cfg[DIS_REMOTE1];
		chan_en[2] = ~state.chan_cfg[DIS_REMOTE2];
		chan_en[3] = ~state.chan_cfg[DIS_SUPPLY];
		chan_en[4] = ~state.chan_cfg[DIS_INPUT1];
		chan_en[5] = ~state.chan_cfg[DIS_INPUT2];
		chan_en[6] = ~state.chan_cfg[DIS_INPUT3];
	end

	// sticky flags: 0..5 temp alarms (int hi, int lo, r1 hi, r1 lo, r2 hi, r2 lo); voltage in separate bits
	always_comb
	begin
		raw_set[0] = temp_above_alarm_i[0] & chan_en[0];
		raw_set[1] = temp_below_alarm_i[0] & chan_en[0];
		raw_set[2] = temp_above_alarm_i[1] & chan_en[1];
		raw_set[3] = temp_below_alarm_i[1] & chan_en[1];
		raw_set[4] = temp_above_alarm_i[2] & chan_en[2];
		raw_set[5] = temp_below_alarm_i[2] & chan_en[2];
		raw_set[6] = 1'b0;
	end

	assign rd_status1 = reg_read_i & (reg_cmd_i == CMD_READ_STATUS1);
	assign rd_status2 = reg_read_i & (reg_cmd_i == CMD_READ_STATUS2);

	assign flag_bus.event_set = raw_set;
	assign flag_bus.clear     = {1'b0, {6{rd_status1}}};

	assign internal_temp_above_alarm = flag_bus.flags[0];
	assign internal_temp_below_alarm = flag_bus.flags[1];
	assign remote1_temp_above_alarm  = flag_bus.flags[2];
	assign remote1_temp_below_alarm  = flag_bus.flags[3];
	assign remote2_temp_above_alarm  = flag_bus.flags[4];
	assign remote2_temp_below_alarm  = flag_bus.flags[5];

	// voltage window alarms, one sticky bit per input
	logic [3:0] volt_q;
	logic [3:0] next_volt;
	genvar gv;
	generate
		for (gv = 0; gv < NUM_VOLT; gv++)
		begin : g_volt
			// set wins over a read clear
			assign next_volt[gv] = (volt_q[gv] & ~rd_status2)
				| (volt_out_of_window_i[gv] & chan_en[3+gv]);
		end
	endgenerate

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			volt_q <= '0;
		else
			volt_q <= next_volt;
	end

	assign volt_alarms = volt_q;

	// status byte images
	always_comb
	begin
		status1 = {(state.conv_state == MCS_SCAN),
			internal_temp_above_alarm, internal_temp_below_alarm,
			remote1_temp_above_alarm, remote1_temp_below_alarm,
			state.diode1_fault_flag,
			remote2_temp_above_alarm, remote2_temp_below_alarm};
		status2 = {state.shutdown_flags[0], state.shutdown_flags[1], state.shutdown_flags[2],
			state.diode2_fault_flag,
			volt_alarms[3], volt_alarms[2], volt_alarms[1], volt_alarms[0]};
	end

	logic [6:0] alarm_src;
	logic       alarm_any;

	always_comb
	begin
		next_state = state;
		alarm_src  = '0;
		alarm_any  = 1'b0;

		// configuration byte 2 write, reserved bit kept zero
		if (reg_write_i && reg_cmd_i == CMD_WRITE_CHAN_CFG)
			next_state.chan_cfg = reg_wdata_i & CHAN_CFG_WMASK;

		// register read data
		if (reg_read_i)
		begin
			case (reg_cmd_i)
				CMD_READ_STATUS1:  next_state.rdata = status1;
				CMD_READ_STATUS2:  next_state.rdata = status2;
				CMD_READ_CHAN_CFG: next_state.rdata = state.chan_cfg;
				default:           next_state.rdata = 8'h00;
			endcase
		end

		// conversion sequencer: round robin over enabled channels; a pass starts at channel 2 when channels 0..2 are all disabled
		case (state.conv_state)
			MCS_IDLE:
			begin
				if (!standby_i && chan_en != 7'h00)
				begin
					next_state.conv_state = MCS_SCAN;
					next_state.channel    = 3'h0;
					if (!chan_en[0])
						next_state.channel = 3'h1;
					if (!chan_en[0] && !chan_en[1])
						next_state.channel = 3'h2;
				end
			end
			MCS_SCAN:
			begin
				if (conv_done_i)
				begin
					next_state.conv_state = MCS_IDLE;
					for (int i = 6; i >= 0; i--)
						if (i > int'(state.channel) && chan_en[i])
						begin
							next_state.channel    = 3'(i);
							next_state.conv_state = MCS_SCAN;
						end
				end
				if (standby_i)
					next_state.conv_state = MCS_IDLE;
			end
			default: next_state.conv_state = MCS_IDLE;
		endcase

		// live shutdown and diode flags, held low for disabled channels
		for (int t = 0; t < NUM_TEMP; t++)
			next_state.shutdown_flags[t] = temp_above_shutdown_i[t] & chan_en[t];
		next_state.diode1_fault_flag = diode1_fault_i & chan_en[1];
		next_state.diode2_fault_flag = diode2_fault_i & chan_en[2];

		// alarm output gating by configuration byte 1
		alarm_src[0] = internal_temp_above_alarm | internal_temp_below_alarm;
		alarm_src[1] = (remote1_temp_above_alarm | remote1_temp_below_alarm) & ~alarm_mask_cfg_i[MASK_REMOTE1];
		alarm_src[2] = (remote2_temp_above_alarm | remote2_temp_below_alarm) & ~alarm_mask_cfg_i[MASK_REMOTE2];
		for (int v = 0; v < NUM_VOLT; v++)
			alarm_src[3+v] = volt_alarms[v] & ~alarm_mask_cfg_i[v];
		alarm_any = (|alarm_src) & ~alarm_mask_cfg_i[MASK_ALL];
		next_state.alarm_n = ~alarm_any;
		next_state.shutdown_out = state.shutdown_flags[0]
			| (state.shutdown_flags[1] & ~alarm_mask_cfg_i[MASK_REMOTE1])
			| (state.shutdown_flags[2] & ~alarm_mask_cfg_i[MASK_REMOTE2]);
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state            <= '0;
			state.conv_state <= MCS_IDLE;
			state.chan_cfg   <= CHAN_CFG_RESET;
			state.alarm_n    <= 1'b1;
		end
		else
			state <= next_state;
	end

	assign reg_rdata_o               = state.rdata;
	assign conv_busy_o               = (state.conv_state == MCS_SCAN) ? 1'b1 : 1'b0;
	assign conv_channel_o            = state.channel;
	assign meas_enable_o             = chan_en;
	assign alarm_n_o                 = state.alarm_n;
	assign thermal_shutdown_output_o = state.shutdown_out;

endmodule
`default_nettype wire

// ### mcs_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcs_conv_model
#(
	parameter int LAT = 3
)
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic reset_i,
	// converter handshake
	input  wire logic busy_i,
	output var  logic done_o
);
	int cnt;
	// each channel takes LAT+1 cycles while the scan is running, the first channel of a pass LAT+2
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cnt <= 0;
			done_o <= 1'b0;
		end
		else
		begin
			done_o <= busy_i && cnt == LAT;
			cnt <= (busy_i && cnt != LAT) ? cnt + 1 : 0;
		end
	end
endmodule
`default_nettype wire

// ### mcs_config_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module mcs_config_status_asserts
	import mcs_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// register access and configuration
	input  wire logic       reg_write_i,
	input  wire logic       reg_read_i,
	input  wire logic [7:0] reg_cmd_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic [7:0] reg_rdata_o,
	input  wire logic [7:0] alarm_mask_cfg_i,
	input  wire logic       standby_i,
	// converter and comparators
	input  wire logic       conv_busy_o,
	input  wire logic [6:0] meas_enable_o,
	input  wire logic [2:0] temp_above_alarm_i,
	input  wire logic [2:0] temp_below_alarm_i,
	input  wire logic [2:0] temp_above_shutdown_i,
	// device outputs
	input  wire logic       alarm_n_o,
	input  wire logic       thermal_shutdown_output_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic [7:0] wd_q;
	logic [2:0] sd_live;
	always_ff @(posedge clk_i) wd_q <= reg_wdata_i;
	assign sd_live = temp_above_shutdown_i & meas_enable_o[2:0] & {~alarm_mask_cfg_i[4], ~alarm_mask_cfg_i[5], 1'b1};
	sequence quiet_s;
		temp_above_alarm_i == 3'h0 && temp_below_alarm_i == 3'h0;
	endsequence
	sequence rd_s1_s;
		reg_read_i && reg_cmd_i == CMD_READ_STATUS1 && temp_above_alarm_i == 3'h0 && temp_below_alarm_i == 3'h0;
	endsequence
	cfg_bit0_zero_a: assert property (reg_read_i && reg_cmd_i == CMD_READ_CHAN_CFG |=> !reg_rdata_o[0])
		else $error("config bit 0 reads one");
	busy_bit_a: assert property (reg_read_i && reg_cmd_i == CMD_READ_STATUS1 |=> reg_rdata_o[7] == $past(conv_busy_o))
		else $error("busy bit wrong");
	meas_enable_a: assert property (reg_write_i && reg_cmd_i == CMD_WRITE_CHAN_CFG |=>
		meas_enable_o == ~{wd_q[4:1], wd_q[6], wd_q[7], wd_q[5]}) else $error("enables wrong");
	alarm_clear_a: assert property (quiet_s ##1 rd_s1_s ##1 rd_s1_s |=> (reg_rdata_o & 8'h7B) == 8'h00)
		else $error("alarms not cleared");
	sd_on_a: assert property ((sd_live != 3'h0) [*3] |-> thermal_shutdown_output_o)
		else $error("shutdown missing");
	sd_off_a: assert property ((sd_live == 3'h0) [*3] |-> !thermal_shutdown_output_o)
		else $error("shutdown stuck");
	mask_all_a: assert property (alarm_mask_cfg_i[MASK_ALL] [*4] |-> alarm_n_o)
		else $error("masked alarm shown");
	restart_a: assert property ((!standby_i && meas_enable_o != 7'h00) [*2] ##0 !conv_busy_o |=> conv_busy_o)
		else $error("converter idle too long");
endmodule
`default_nettype wire

// ### mcs_config_status_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; $display("ERROR %0t: got %h exp %h", $time, got, exp); end end
module mcs_config_status_tb_top;
	import mcs_pkg::*;
	logic       clk_i, reset_i, reg_write_i, reg_read_i, standby_i, diode1_fault_i, diode2_fault_i;
	logic [7:0] reg_cmd_i, reg_wdata_i, alarm_mask_cfg_i, reg_rdata_o;
	logic [2:0] temp_above_alarm_i, temp_below_alarm_i, temp_above_shutdown_i, conv_channel_o;
	logic [3:0] volt_out_of_window_i;
	logic [6:0] meas_enable_o;
	logic       conv_done_i, conv_busy_o, alarm_n_o, thermal_shutdown_output_o;
	int         fail_count = 0;
	int         checks = 0;
	int         chan_of[8] = '{0, 3, 4, 5, 6, 0, 2, 1};
	int         s1_pos[6] = '{6, 4, 1, 5, 3, 0};
	mcs_config_status DUT (.clk_i, .reset_i, .reg_write_i, .reg_read_i, .reg_cmd_i, .reg_wdata_i, .reg_rdata_o,
		.alarm_mask_cfg_i, .standby_i, .conv_done_i, .conv_busy_o, .conv_channel_o, .meas_enable_o,
		.temp_above_alarm_i, .temp_below_alarm_i, .temp_above_shutdown_i, .volt_out_of_window_i,
		.diode1_fault_i, .diode2_fault_i, .alarm_n_o, .thermal_shutdown_output_o);
	mcs_conv_model u_conv (.clk_i, .reset_i, .busy_i(conv_busy_o), .done_o(conv_done_i));
	always #10 clk_i = ~clk_i;
	task automatic step(input int n);
		reg_write_i = 1'b0;
		reg_read_i = 1'b0;
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
		reg_read_i = 1'b0;
		reg_write_i = 1'b1;
		reg_cmd_i = cmd;
		reg_wdata_i = data;
		@(posedge clk_i);
		#1;
	endtask
	task automatic rd(input logic [7:0] cmd, input logic [7:0] msk, input logic [7:0] exp);
		reg_write_i = 1'b0;
		reg_read_i = 1'b1;
		reg_cmd_i = cmd;
		@(posedge clk_i);
		#1;
		`CHK(reg_rdata_o & msk, exp)
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		clk_i = 1'b0;
		reset_i = 1'b1;
		{reg_write_i, reg_read_i, standby_i, diode1_fault_i, diode2_fault_i, reg_cmd_i, reg_wdata_i} = '0;
		{alarm_mask_cfg_i, temp_above_alarm_i, temp_below_alarm_i, temp_above_shutdown_i, volt_out_of_window_i} = '0;
		repeat (5) @(posedge clk_i);
		#1;
		reset_i = 1'b0;
		for (int i = 0; i < 20 && conv_busy_o !== 1'b1; i++)
			step(1);
		`CHK(conv_busy_o, 1'b1)
		if (conv_busy_o !== 1'b1)
			wrap_up();
		`CHK(conv_channel_o, 3'h0)
		rd(CMD_READ_CHAN_CFG, 8'hFF, CHAN_CFG_RESET);
		rd(CMD_READ_STATUS1, 8'h7F, 8'h00);
		wr(CMD_WRITE_CHAN_CFG, 8'hFF);
		rd(CMD_READ_CHAN_CFG, 8'hFF, 8'hFE);
		for (int b = 0; b < 8; b++)
		begin
			wr(CMD_WRITE_CHAN_CFG, 8'h01 << b);
			`CHK(meas_enable_o, (b == 0) ? 7'h7F : ~(7'h01 << chan_of[b]))
		end
		wr(CMD_WRITE_CHAN_CFG, 8'h00);
		$display("test config done");
		for (int i = 0; i < 6; i++)
		begin
			temp_above_alarm_i = (i < 3) ? 3'h1 << i : 3'h0;
			temp_below_alarm_i = (i < 3) ? 3'h0 : 3'h1 << (i - 3);
			step(1);
			{temp_above_alarm_i, temp_below_alarm_i} = '0;
			step(3);
			`CHK(alarm_n_o, 1'b0)
			rd(CMD_READ_STATUS1, 8'h7F, 8'h01 << s1_pos[i]);
		end
		rd(CMD_READ_STATUS1, 8'h7F, 8'h00);
		step(3);
		`CHK(alarm_n_o, 1'b1)
		diode1_fault_i = 1'b1;
		step(2);
		rd(CMD_READ_STATUS1, 8'h7F, 8'h04);
		rd(CMD_READ_STATUS1, 8'h7F, 8'h04);
		diode1_fault_i = 1'b0;
		step(2);
		rd(CMD_READ_STATUS1, 8'h7F, 8'h00);
		$display("test status 1 done");
		alarm_mask_cfg_i = 8'h30;
		diode2_fault_i = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			temp_above_shutdown_i = (i < 3) ? 3'h1 << i : 3'h0;
			volt_out_of_window_i = 4'h1 << i;
			step(1);
			volt_out_of_window_i = 4'h0;
			step(3);
			`CHK(thermal_shutdown_output_o, 1'(i == 0))
			rd(CMD_READ_STATUS2, 8'hFF, 8'h10 | (8'h01 << i) | ((i < 3) ? 8'h80 >> i : 8'h00));
		end
		{alarm_mask_cfg_i, diode2_fault_i} = '0;
		step(3);
		rd(CMD_READ_STATUS2, 8'hFF, 8'h00);
		$display("test status 2 done");
		wr(CMD_WRITE_CHAN_CFG, 8'hFE);
		{temp_above_alarm_i, temp_below_alarm_i, temp_above_shutdown_i, volt_out_of_window_i} = '1;
		{diode1_fault_i, diode2_fault_i} = 2'h3;
		step(4);
		`CHK(thermal_shutdown_output_o, 1'b0)
		{temp_above_alarm_i, temp_below_alarm_i, temp_above_shutdown_i, volt_out_of_window_i} = '0;
		step(1);
		rd(CMD_READ_STATUS1, 8'h7F, 8'h00);
		rd(CMD_READ_STATUS2, 8'hFF, 8'h00);
		{diode1_fault_i, diode2_fault_i} = 2'h0;
		wr(CMD_WRITE_CHAN_CFG, 8'h00);
		$display("test disable done");
		alarm_mask_cfg_i = 8'h80;
		temp_above_alarm_i = 3'h1;
		step(1);
		temp_above_alarm_i = 3'h0;
		step(4);
		`CHK(alarm_n_o, 1'b1)
		alarm_mask_cfg_i = 8'h00;
		step(3);
		`CHK(alarm_n_o, 1'b0)
		rd(CMD_READ_STATUS1, 8'h7F, 8'h40);
		$display("test mask done");
		standby_i = 1'b1;
		step(2);
		`CHK(conv_busy_o, 1'b0)
		standby_i = 1'b0;
		step(2);
		`CHK(conv_busy_o, 1'b1)
		$display("test standby done");
		wrap_up();
	end
endmodule
bind mcs_config_status mcs_config_status_asserts u_chk (.clk_i, .reset_i, .reg_write_i, .reg_read_i,
	.reg_cmd_i, .reg_wdata_i, .reg_rdata_o, .alarm_mask_cfg_i, .standby_i, .conv_busy_o, .meas_enable_o,
	.temp_above_alarm_i, .temp_below_alarm_i, .temp_above_shutdown_i, .alarm_n_o, .thermal_shutdown_output_o);
`default_nettype wire
